// >>> hdl/host_memory_access_port.sv
`default_nettype none
module host_memory_access_port
    import host_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic address_latch_strobe,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [15:0] host_addr_data_bus_in,
    output logic [15:0] host_addr_data_bus_out,
    output logic host_addr_data_bus_oe_n,
    output logic port_acknowledge,
    input wire logic [2:0] boot_mode,
    input wire proc_bus_s proc_bus,
    output logic [15:0] proc_rdata,
    output logic proc_run,
    output logic [13:0] proc_fetch_addr
);
    logic [23:0] program_memory [pm_depth];
    logic [15:0] data_memory [dm_depth];

    logic [15:0] start_address_register_r;
    logic [15:0] memory_page_selection_r;
    logic [15:0] bus_in_r;
    logic latch_d_r;
    logic rd_d_r;
    logic wr_d_r;
    logic pm_low_phase_r;
    logic [15:0] pm_high_r;
    logic is_read_r;
    logic boot_mode_host_r;
    logic boot_sampled_r;
    logic held_r;
    port_state_e state_r;
    logic [15:0] rdata_r;
    logic oe_n_r;
    logic ack_r;
    logic [15:0] proc_rdata_r;

    function automatic logic is_ctrl_addr(input logic [13:0] a);
        is_ctrl_addr = (a[13:4] == control_reg_base[13:4]);
    endfunction : is_ctrl_addr

    logic req_rd;
    logic req_wr;
    logic latch_fall;
    logic [13:0] cur_addr;
    logic cur_pm;
    assign req_rd = !port_select_n && !host_read_strobe_n && !rd_d_r;
    assign req_wr = !port_select_n && !host_write_strobe_n && !wr_d_r;
    assign latch_fall = latch_d_r && !address_latch_strobe;
    assign cur_addr = start_address_register_r[13:0];
    assign cur_pm = !start_address_register_r[mem_type_bit];

    // Previous strobe levels for edge detection
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            latch_d_r <= 1'b0;
            rd_d_r <= 1'b0;
            wr_d_r <= 1'b0;
            bus_in_r <= 16'h0000;
        end
        else
        begin
            latch_d_r <= address_latch_strobe && !port_select_n;
            rd_d_r <= !port_select_n && !host_read_strobe_n;
            wr_d_r <= !port_select_n && !host_write_strobe_n;
            bus_in_r <= host_addr_data_bus_in;
        end
    end

    // Access sequencer: one cycle sync, one cycle memory
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= st_idle;
            is_read_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                st_idle:
                    if (req_rd || req_wr)
                    begin
                        state_r <= st_sync;
                        is_read_r <= req_rd;
                    end
                st_sync: state_r <= st_access;
                st_access: state_r <= st_done;
                st_done:
                    if (port_select_n || (host_read_strobe_n && host_write_strobe_n))
                        state_r <= st_idle;
            endcase
        end
    end

    // Acknowledge drops while an access is pending
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (state_r == st_idle) && !(req_rd || req_wr);
    end

    // Address and overlay registers, host side has priority over processor
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            start_address_register_r <= start_address_reset;
            memory_page_selection_r <= overlay_select_reset;
            pm_low_phase_r <= 1'b0;
        end
        else if (latch_fall)
        begin
            if (bus_in_r[latch_bit])
                memory_page_selection_r <= {memory_page_selection_r[15:8], bus_in_r[7:0]};
            else
                start_address_register_r <= {1'b0, bus_in_r[mem_type_bit:0]};
            pm_low_phase_r <= 1'b0;
        end
        else if (state_r == st_access)
        begin
            if (cur_pm && !pm_low_phase_r)
                pm_low_phase_r <= 1'b1;
            else
            begin
                pm_low_phase_r <= 1'b0;
                start_address_register_r[13:0] <= cur_addr + 14'h0001;
            end
        end
        else if (proc_bus.wr && proc_bus.addr == start_address_offset)
            start_address_register_r <= proc_bus.wdata;
        else if (proc_bus.wr && proc_bus.addr == overlay_select_offset)
            memory_page_selection_r <= proc_bus.wdata;
    end

    // Memory access port; host data writes to control register addresses are dropped
    always_ff @(posedge ref_clk)
    begin
        if (state_r == st_access && !is_read_r)
        begin
            if (cur_pm && !pm_low_phase_r)
                pm_high_r <= bus_in_r;
            else if (cur_pm)
                program_memory[cur_addr] <= {pm_high_r, bus_in_r[7:0]};
            else if (!is_ctrl_addr(cur_addr))
                data_memory[cur_addr] <= bus_in_r;
        end
        else if (proc_bus.wr && !is_ctrl_addr(proc_bus.addr))
            data_memory[proc_bus.addr] <= proc_bus.wdata;
    end

    // Host read data; short-read timing mode keeps data one cycle longer
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdata_r <= 16'h0000;
            oe_n_r <= 1'b1;
        end
        else if (state_r == st_access && is_read_r)
        begin
            if (cur_pm)
                rdata_r <= pm_low_phase_r ? {8'h00, program_memory[cur_addr][7:0]}
                                          : program_memory[cur_addr][23:8];
            else if (is_ctrl_addr(cur_addr))
                rdata_r <= 16'h0000;
            else
                rdata_r <= data_memory[cur_addr];
            oe_n_r <= 1'b0;
        end
        else if (host_read_strobe_n || port_select_n)
        begin
            if (state_r != st_done || !memory_page_selection_r[short_read_bit])
                oe_n_r <= 1'b1;
        end
    end

    // Processor reads of its own registers and data memory
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            proc_rdata_r <= 16'h0000;
        else if (proc_bus.rd)
        begin
            if (proc_bus.addr == start_address_offset)
                proc_rdata_r <= start_address_register_r;
            else if (proc_bus.addr == overlay_select_offset)
                proc_rdata_r <= memory_page_selection_r;
            else
                proc_rdata_r <= data_memory[proc_bus.addr];
        end
    end

    // Boot strap caught after reset release, not under reset
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            boot_sampled_r <= 1'b0;
            boot_mode_host_r <= 1'b0;
            held_r <= 1'b1;
        end
        else if (!boot_sampled_r)
        begin
            boot_sampled_r <= 1'b1;
            boot_mode_host_r <= (boot_mode == boot_mode_host);
            held_r <= (boot_mode == boot_mode_host);
        end
        else if (held_r && state_r == st_access && !is_read_r && cur_pm && pm_low_phase_r
                 && cur_addr == boot_release_addr)
            held_r <= 1'b0;
    end

    assign host_addr_data_bus_out = rdata_r;
    assign host_addr_data_bus_oe_n = oe_n_r;
    assign port_acknowledge = ack_r;
    assign proc_rdata = proc_rdata_r;
    assign proc_run = boot_sampled_r && !held_r;
    assign proc_fetch_addr = boot_release_addr;
endmodule : host_memory_access_port
`default_nettype wire

// >>> hdl/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
    localparam logic [13:0] start_address_offset = 14'h3fe0;
    localparam logic [13:0] overlay_select_offset = 14'h3fe7;
    localparam logic [13:0] control_reg_base = 14'h3fe0;
    localparam logic [15:0] start_address_reset = 16'h0000;
    localparam logic [15:0] overlay_select_reset = 16'h0000;
    localparam int latch_bit = 15;
    localparam int mem_type_bit = 14;
    localparam int short_read_bit = 14;
    localparam logic [2:0] boot_mode_host = 3'h5;
    localparam logic [13:0] boot_release_addr = 14'h0000;
    localparam int pm_depth = 16384;
    localparam int dm_depth = 16384;

    typedef enum logic [1:0] {st_idle, st_sync, st_access, st_done} port_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [13:0] addr;
        logic [15:0] wdata;
    } proc_bus_s;
endpackage : host_port_pkg
`default_nettype wire

// >>> verification/host_port_props.sv
`default_nettype none
module host_port_props
    import host_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic port_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic host_addr_data_bus_oe_n,
    input wire logic port_acknowledge,
    input wire logic proc_run,
    input wire logic [13:0] proc_fetch_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_rd;
        $fell(host_read_strobe_n) && !port_select_n && port_acknowledge;
    endsequence
    property p_rst;
        $fell(rst) |-> !port_acknowledge && !proc_run && host_addr_data_bus_oe_n;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_ack_lo;
        ($fell(host_read_strobe_n) || $fell(host_write_strobe_n)) && !port_select_n && port_acknowledge
            |-> ##[1:2] !port_acknowledge;
    endproperty
    a_ack_lo: assert property (p_ack_lo) else $error("ack stayed high");
    property p_rd_data;
        s_rd |-> ##[2:3] !host_addr_data_bus_oe_n;
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data late");
    property p_ack_back;
        $rose(host_read_strobe_n) && !port_acknowledge |-> ##[1:3] port_acknowledge;
    endproperty
    a_ack_back: assert property (p_ack_back) else $error("ack not back");
    property p_idle_bus;
        host_read_strobe_n [*3] |-> host_addr_data_bus_oe_n;
    endproperty
    a_idle_bus: assert property (p_idle_bus) else $error("bus driven idle");
    property p_sel_bus;
        !host_addr_data_bus_oe_n |-> !port_select_n || !$past(port_select_n) || !$past(port_select_n, 2);
    endproperty
    a_sel_bus: assert property (p_sel_bus) else $error("bus driven unselected");
    property p_fetch;
        proc_run |-> proc_fetch_addr == boot_release_addr;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not at zero");
    property p_run_hold;
        proc_run |=> proc_run;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("run dropped");
endmodule : host_port_props
`default_nettype wire

// >>> verification/host_bus_model.sv
`default_nettype none
module host_bus_model
(
    input wire logic ref_clk,
    input wire logic port_acknowledge,
    input wire logic [15:0] host_addr_data_bus_out,
    input wire logic host_addr_data_bus_oe_n,
    output var logic port_select_n,
    output var logic address_latch_strobe,
    output var logic host_read_strobe_n,
    output var logic host_write_strobe_n,
    output logic [15:0] host_addr_data_bus_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] hv = 16'h0000;
    logic drv = 1'b0;
    // Released bus shows the inverse so stale data never passes
    assign host_addr_data_bus_in = !host_addr_data_bus_oe_n ? host_addr_data_bus_out : (drv ? hv : ~hv);
    initial {port_select_n, address_latch_strobe, host_read_strobe_n, host_write_strobe_n} = 4'hb;
    task automatic wait_ack();
        repeat (16) if (!port_acknowledge) @(negedge ref_clk);
    endtask : wait_ack
    task automatic latch_addr(input logic [15:0] v);
        wait_ack();
        {port_select_n, address_latch_strobe, drv} = 3'h3;
        hv = v;
        @(negedge ref_clk);
        address_latch_strobe = 1'b0;
        @(negedge ref_clk);
        {port_select_n, drv} = 2'h2;
    endtask : latch_addr
    task automatic xfer(input logic rd, input logic [15:0] v, output logic [15:0] q);
        wait_ack();
        {port_select_n, host_read_strobe_n, host_write_strobe_n, drv} = {1'b0, !rd, rd, !rd};
        hv = v;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        q = host_addr_data_bus_in;
        {port_select_n, host_read_strobe_n, host_write_strobe_n, drv} = 4'he;
    endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// >>> verification/tb.sv
`default_nettype none
module tb
    import host_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0, rst = 1'b1, port_select_n, address_latch_strobe, host_read_strobe_n;
    logic host_write_strobe_n, host_addr_data_bus_oe_n, port_acknowledge, proc_run;
    logic [15:0] host_addr_data_bus_in, host_addr_data_bus_out, proc_rdata, q;
    logic [13:0] proc_fetch_addr;
    logic [2:0] boot_mode = boot_mode_host;
    proc_bus_s proc_bus = '0;
    int error_cnt = 0, samples_checked = 0, seed = 50, dm[int], pm;
    host_memory_access_port dut (.*);
    host_bus_model host (.*);
    always #12.5 ref_clk = ~ref_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic preg(input logic wr, input logic [13:0] a, input logic [15:0] d);
        proc_bus = {wr, !wr, a, d};
        @(negedge ref_clk);
        proc_bus = '0;
    endtask : preg
    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(16'(proc_run), 16'h0000);
        host.latch_addr(16'h4100);
        for (int i = 0; i < 4; i++)
        begin
            dm[i] = $random(seed);
            host.xfer(1'b0, 16'(dm[i]), q);
        end
        check(16'(proc_run), 16'h0000);
        preg(1'b1, start_address_offset, 16'h4100);
        preg(1'b0, start_address_offset, '0);
        check(proc_rdata, 16'h4100);
        for (int i = 0; i < 4; i++)
        begin
            host.xfer(1'b1, '0, q);
            check(q, 16'(dm[i]));
        end
        host.latch_addr(16'h7fe8);
        host.xfer(1'b0, 16'h1234, q);
        host.latch_addr(16'h7fe8);
        host.xfer(1'b1, '0, q);
        check(q, 16'h0000);
        host.latch_addr(16'h8003);
        preg(1'b0, overlay_select_offset, '0);
        check({8'h00, proc_rdata[7:0]}, 16'h0003);
        preg(1'b1, overlay_select_offset, 16'h4000);
        preg(1'b0, overlay_select_offset, '0);
        check(proc_rdata, 16'h4000);
        pm = $random(seed) & 32'h00ffffff;
        host.latch_addr(16'h0000);
        host.xfer(1'b0, 16'(pm >> 8), q);
        host.xfer(1'b0, 16'(pm & 32'h000000ff), q);
        repeat (2) @(negedge ref_clk);
        check(16'(proc_run), 16'h0001);
        host.latch_addr(16'h0000);
        host.xfer(1'b1, '0, q);
        check(q, 16'(pm >> 8));
        host.xfer(1'b1, '0, q);
        check({8'h00, q[7:0]}, 16'(pm & 32'h000000ff));
        // Second reset with a random non-host boot mode: processor runs at once
        rst = 1'b1;
        boot_mode = 3'($random(seed));
        if (boot_mode == boot_mode_host)
            boot_mode = 3'h0;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(16'(proc_run), 16'h0001);
        check(16'(port_acknowledge), 16'h0001);
        preg(1'b0, overlay_select_offset, '0);
        check(proc_rdata, overlay_select_reset);
        stop_test();
    end
    initial
    begin
        #50us;
        error_cnt++;
        stop_test();
    end
endmodule : tb
bind host_memory_access_port host_port_props chk (.*);
`default_nettype wire
